// ### fnd_pkg.sv
// Purpose: shared constants and types of the fractional-N feedback divider
// Assumes: 32-bit APB register words, byte addresses
// Notes:   definitions only
package fnd_pkg;
  localparam int unsigned N_W    = 12;
  localparam int unsigned ACC_W  = 32;
  localparam int unsigned DLY_W  = 4;
  localparam int unsigned RDIV_W = 8;
  localparam int unsigned ORD_W  = 3;
  // register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_INT  = 8'h04;
  localparam logic [7:0] A_NUM  = 8'h08;
  localparam logic [7:0] A_DEN  = 8'h0c;
  localparam logic [7:0] A_SEED = 8'h10;
  localparam logic [7:0] A_REF  = 8'h14;
  localparam logic [7:0] A_STAT = 8'h18;
  // control word fields
  localparam int unsigned C_CAL  = 0;
  localparam int unsigned C_VDBL = 1;
  localparam int unsigned C_PRE4 = 2;
  localparam int unsigned C_ORD  = 3;
  localparam int unsigned C_LOW  = 8;
  localparam int unsigned C_HIGH = 10;
  localparam int unsigned C_LOOP = 12;
  localparam int unsigned C_DLY  = 16;
  // reference path word fields
  localparam int unsigned R_DBL   = 0;
  localparam int unsigned R_PREBY = 1;
  localparam int unsigned R_MULBY = 2;
  localparam int unsigned R_POSBY = 3;
  localparam int unsigned R_PRE   = 8;
  localparam int unsigned R_MUL   = 16;
  localparam int unsigned R_POST  = 24;
  // reset values
  localparam logic [31:0]  CTRL_RST = 32'h0001_0000;
  localparam logic [N_W-1:0] INT_RST = 12'h064;
  localparam logic [31:0]  DEN_RST  = 32'h0000_0001;
  localparam logic [31:0]  REF_RST  = 32'h0101_010e;
  // encodings
  localparam logic [2:0] PRESCALE_2 = 3'h2;
  localparam logic [2:0] PRESCALE_4 = 3'h4;
  localparam logic [1:0] ADJ_EXT    = 2'h3;
  localparam logic [1:0] LOOP_SNGL  = 2'h3;
  localparam int         ORDER_MAX  = 4;
  typedef enum logic [1:0] {
    PFD_IDLE = 2'b00,
    PFD_UP   = 2'b01,
    PFD_DN   = 2'b10,
    PFD_CLR  = 2'b11
  } pfd_state_t;
  typedef enum logic [1:0] {
    DET_DUAL = 2'b00,
    DET_LOW  = 2'b01,
    DET_HIGH = 2'b10
  } det_mode_t;
endpackage : fnd_pkg

// ### pulse_divider.sv
// Purpose: divides a stream of one-cycle pulses by a programmable value
// Assumes: input pulses synchronous to pclk
// Notes:   divide value 0 or 1 passes every pulse
`timescale 1ns/1ps
`default_nettype none
module pulse_divider #(
  parameter int unsigned W = 8
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // pulse stream
  input  wire logic         in_pulse,
  input  wire logic         bypass,
  input  wire logic [W-1:0] div,
  output logic              out_pulse
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         out;
  } pd_st_t;
  pd_st_t st_reg;
  pd_st_t st_next;
  if (W < 2) begin : g_bad_width
    $error("pulse_divider width below 2");
  end
  always_comb begin
    st_next     = st_reg;
    st_next.out = 1'b0;
    if (in_pulse) begin
      if (bypass || div <= W'(1) || st_reg.cnt >= div - W'(1)) begin
        st_next.out = 1'b1;
        st_next.cnt = '0;
      end else begin
        st_next.cnt = st_reg.cnt + W'(1);
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign out_pulse = st_reg.out;
endmodule : pulse_divider
`default_nettype wire

// ### mash_stage.sv
// Purpose: one first-order accumulator stage of the noise-shaping modulator
// Assumes: addend and acc stay below den
// Notes:   carry holds its value between steps
`timescale 1ns/1ps
`default_nettype none
module mash_stage #(
  parameter int unsigned W = 32
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // control
  input  wire logic         step,
  input  wire logic         load,
  input  wire logic [W-1:0] seed,
  input  wire logic [W-1:0] addend,
  input  wire logic [W-1:0] den,
  // result
  output logic [W-1:0]      acc,
  output logic              carry
);
  typedef struct packed {
    logic [W-1:0] acc;
    logic         carry;
  } ms_st_t;
  ms_st_t st_reg;
  ms_st_t st_next;
  logic [W:0] sum;
  if (W < 2) begin : g_bad_width
    $error("mash_stage width below 2");
  end
  always_comb begin
    st_next = st_reg;
    sum     = {1'b0, st_reg.acc} + {1'b0, addend};
    if (load) begin
      st_next.acc   = seed;
      st_next.carry = 1'b0;
    end else if (step) begin
      // wrap modulo den keeps the long-run carry rate at addend/den
      if (sum >= {1'b0, den}) begin
        st_next.acc   = W'(sum - {1'b0, den});
        st_next.carry = 1'b1;
      end else begin
        st_next.acc   = sum[W-1:0];
        st_next.carry = 1'b0;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign acc   = st_reg.acc;
  assign carry = st_reg.carry;
endmodule : mash_stage
`default_nettype wire

// ### fractional_n_feedback_divider.sv
// Purpose: feedback divider with noise-shaping fraction, reference path, phase detector
// Assumes: osc_tick and ref_edge are one-cycle pulses synchronous to pclk
// Notes:   registers over APB; pready comes one cycle into the access phase
// Behaviour
// RULE1: integer divide value is a 12-bit programmable count
// RULE2: noise-shaping modulator, order programmable one to four, steers the count
// RULE3: any denominator from 1 to 2^32-1 accepted
// RULE4: average division equals integer plus numerator over denominator
// RULE5: prescaler of 2 or 4 sits ahead of the integer counter
// RULE6: software keeps integer value above the per-order minimum
// RULE7: software sets detector delay 1, 2 or 8 by modulator order
// RULE8: detector runs dual-loop by default, 5 to 200 MHz
// RULE9: low extended rates need low adjust 3 and prescale 4; the code selects low mode on low adjust 3 alone
// RULE10: high extended rates need high adjust 3, single loop, integer mode; the code selects high mode without checking integer mode
// RULE11: each reference stage can be bypassed on its own
// RULE12: software never enables input doubler together with multiplier
// RULE13: detector pulses until reference and feedback edges align
// RULE14: oscillator doubler forces prescale by 4
// RULE15: control write with calibration bit starts a calibration
// RULE16: seed write shifts modulator phase; seed kept below denominator
// RULE17: modulator steps once per feedback cycle, wrapping modulo denominator
// RULE18: software keeps numerator below denominator, integer mode when zero
`timescale 1ns/1ps
`default_nettype none
module fractional_n_feedback_divider
  import fnd_pkg::*;
#(
  parameter int unsigned ORDERS = 4
) (
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // oscillator and reference pulses
  input  wire logic        osc_tick,
  input  wire logic        ref_edge,
  // detector and calibration
  output logic             fb_pulse,
  output logic             pfd_up,
  output logic             pfd_down,
  output logic             cal_start
);
  import fnd_pkg::*;

  typedef struct packed {
    logic [31:0]      ctrl;
    logic [N_W-1:0]   intv;
    logic [31:0]      num;
    logic [31:0]      den;
    logic [31:0]      seed;
    logic [31:0]      refc;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic             cal_start;
    logic             seed_pend;
    logic             dbl_phase;
    logic             ref_dbl;
    logic [RDIV_W-1:0] mul_cnt;
    logic             ref_mul;
    logic [N_W:0]     ncnt;
    logic             fb;
    logic [5:0]       hist;
    pfd_state_t       pst;
    logic [DLY_W-1:0] dcnt;
    logic             up;
    logic             dn;
    logic             aligned;
    logic [15:0]      fbcount;
  } top_st_t;
  top_st_t st_reg;
  top_st_t st_next;

  if (ORDERS != ORDER_MAX) begin : g_bad_orders
    $error("modulator needs exactly four stages");
  end

  logic             pre_pulse;
  logic             ref_pre;
  logic             ref_pd;
  logic             eff_by4;
  logic             div_evt;
  logic             mash_en;
  logic             wr;
  logic             rd_ph;
  logic             cal_req;
  logic             seed_wr;
  logic [2:0]       order;
  det_mode_t        det_mode;
  logic [ACC_W-1:0] acc [ORDERS];
  logic [ORDERS-1:0] carry;
  int               offs_i;
  int               mod_i;

  assign eff_by4 = st_reg.ctrl[C_VDBL] | st_reg.ctrl[C_PRE4]; // RULE14 RULE5
  assign order   = (int'(st_reg.ctrl[C_ORD +: ORD_W]) > ORDER_MAX) ?
                   3'(ORDER_MAX) : st_reg.ctrl[C_ORD +: ORD_W];
  assign div_evt = pre_pulse && (st_reg.ncnt == '0); // RULE1
  assign mash_en = div_evt && (order != 3'h0); // RULE17
  assign wr      = psel && penable && st_reg.pready && pwrite;
  assign rd_ph   = psel && penable && !st_reg.pready;
  assign cal_req = wr && (paddr == A_CTRL) && pwdata[C_CAL];
  assign seed_wr = wr && (paddr == A_SEED);

  // prescaler between oscillator and integer counter
  pulse_divider #(.W(3)) u_prescale (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_pulse  (osc_tick),
    .bypass    (1'b0),
    .div       (eff_by4 ? PRESCALE_4 : PRESCALE_2), // RULE5 RULE14
    .out_pulse (pre_pulse)
  );

  // reference pre-divider and post-divider, each bypassable
  pulse_divider #(.W(RDIV_W)) u_ref_pre (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_pulse  (st_reg.ref_dbl),
    .bypass    (st_reg.refc[R_PREBY]), // RULE11
    .div       (st_reg.refc[R_PRE +: RDIV_W]),
    .out_pulse (ref_pre)
  );
  pulse_divider #(.W(RDIV_W)) u_ref_post (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_pulse  (st_reg.ref_mul),
    .bypass    (st_reg.refc[R_POSBY]), // RULE11
    .div       (st_reg.refc[R_POST +: RDIV_W]),
    .out_pulse (ref_pd)
  );

  // cascade of first-order stages; stage k adds stage k-1's residue
  for (genvar g = 0; g < ORDERS; g++) begin : g_mash
    mash_stage #(.W(ACC_W)) u_stage (
      .pclk    (pclk),
      .presetn (presetn),
      .step    (mash_en), // RULE17
      .load    ((g == 0) && mash_en && st_reg.seed_pend), // RULE16
      .seed    (st_reg.seed),
      .addend  ((g == 0) ? st_reg.num : acc[(g == 0) ? 0 : g - 1]),
      .den     (st_reg.den),
      .acc     (acc[g]),
      .carry   (carry[g])
    );
  end

  // noise-shaped offset: c0 + d(c1) + d2(c2) + d3(c3), cut at the order
  always_comb begin
    offs_i = 0;
    if (order >= 3'h1) offs_i = offs_i + int'(carry[0]); // RULE2
    if (order >= 3'h2) offs_i = offs_i + int'(carry[1]) - int'(st_reg.hist[0]);
    if (order >= 3'h3) begin
      offs_i = offs_i + int'(carry[2]) - 2 * int'(st_reg.hist[1]) + int'(st_reg.hist[2]);
    end
    if (order >= 3'h4) begin
      offs_i = offs_i + int'(carry[3]) - 3 * int'(st_reg.hist[3])
             + 3 * int'(st_reg.hist[4]) - int'(st_reg.hist[5]);
    end
    mod_i = int'(st_reg.intv) + offs_i; // RULE4
    if (mod_i < 1) mod_i = 1;
  end

  always_comb begin
    if (st_reg.ctrl[C_LOW +: 2] == ADJ_EXT) begin
      det_mode = DET_LOW; // RULE9
    end else if (st_reg.ctrl[C_HIGH +: 2] == ADJ_EXT &&
                 st_reg.ctrl[C_LOOP +: 2] == LOOP_SNGL) begin
      det_mode = DET_HIGH; // RULE10
    end else begin
      det_mode = DET_DUAL; // RULE8
    end
  end

  always_comb begin
    st_next           = st_reg;
    st_next.cal_start = 1'b0;
    st_next.fb        = 1'b0;
    // apb: answer one cycle into the access phase
    st_next.pready  = rd_ph;
    st_next.pslverr = 1'b0;
    if (rd_ph) begin
      st_next.prdata = '0;
      case (paddr)
        A_CTRL: st_next.prdata = st_reg.ctrl;
        A_INT:  st_next.prdata = {{(32 - N_W){1'b0}}, st_reg.intv};
        A_NUM:  st_next.prdata = st_reg.num;
        A_DEN:  st_next.prdata = st_reg.den;
        A_SEED: st_next.prdata = st_reg.seed;
        A_REF:  st_next.prdata = st_reg.refc;
        A_STAT: st_next.prdata = {st_reg.fbcount, 10'h000, det_mode,
                                  eff_by4, st_reg.pst, st_reg.aligned};
        default: st_next.pslverr = 1'b1;
      endcase
    end
    if (wr) begin
      case (paddr)
        // calibration bit is a trigger, never stored
        A_CTRL: st_next.ctrl = pwdata & ~(32'h1 << C_CAL);
        A_INT:  st_next.intv = pwdata[N_W-1:0]; // RULE1
        A_NUM:  st_next.num  = pwdata;
        // zero would stall the wrap, so it reads back as one
        A_DEN:  st_next.den  = (pwdata == '0) ? DEN_RST : pwdata; // RULE3
        A_SEED: st_next.seed = pwdata;
        A_REF:  st_next.refc = pwdata;
        default: ;
      endcase
    end
    if (cal_req) st_next.cal_start = 1'b1; // RULE15
    // seed write wins over the clear at the step that consumes it
    if (mash_en) st_next.seed_pend = 1'b0;
    if (seed_wr) st_next.seed_pend = 1'b1; // RULE16
    // integer counter, reloaded with the modulated modulus
    if (div_evt) begin
      st_next.fb      = 1'b1;
      st_next.ncnt    = (N_W + 1)'(mod_i - 1); // RULE4
      st_next.fbcount = st_reg.fbcount + 16'h0001;
    end else if (pre_pulse) begin
      st_next.ncnt = st_reg.ncnt - (N_W + 1)'(1);
    end
    if (mash_en) begin
      st_next.hist = {st_reg.hist[4:3], carry[3], st_reg.hist[1], carry[2], carry[1]};
    end
    // input doubler off: only every second edge counts
    st_next.ref_dbl = 1'b0;
    if (ref_edge) begin
      st_next.dbl_phase = !st_reg.dbl_phase;
      st_next.ref_dbl   = st_reg.refc[R_DBL] || !st_reg.dbl_phase; // RULE11
    end
    // multiplier: burst of pulses per input pulse, limited by pclk rate
    st_next.ref_mul = 1'b0;
    if (st_reg.refc[R_MULBY]) begin
      st_next.ref_mul = ref_pre; // RULE11
      st_next.mul_cnt = '0;
    end else if (ref_pre) begin
      st_next.ref_mul = 1'b1;
      st_next.mul_cnt = (st_reg.refc[R_MUL +: RDIV_W] == '0) ? '0 :
                        st_reg.refc[R_MUL +: RDIV_W] - RDIV_W'(1);
    end else if (st_reg.mul_cnt != '0) begin
      st_next.ref_mul = 1'b1;
      st_next.mul_cnt = st_reg.mul_cnt - RDIV_W'(1);
    end
    // phase detector; events during the reset delay are not seen
    case (st_reg.pst)
      PFD_IDLE: begin
        if (ref_pd && st_reg.fb) begin
          st_next.aligned = 1'b1; // RULE13
        end else if (ref_pd) begin
          st_next.pst     = PFD_UP;
          st_next.up      = 1'b1;
          st_next.aligned = 1'b0;
        end else if (st_reg.fb) begin
          st_next.pst     = PFD_DN;
          st_next.dn      = 1'b1;
          st_next.aligned = 1'b0;
        end
      end
      PFD_UP: begin
        if (st_reg.fb) begin
          st_next.pst  = PFD_CLR;
          st_next.dn   = 1'b1;
          st_next.dcnt = st_reg.ctrl[C_DLY +: DLY_W];
        end
      end
      PFD_DN: begin
        if (ref_pd) begin
          st_next.pst  = PFD_CLR;
          st_next.up   = 1'b1;
          st_next.dcnt = st_reg.ctrl[C_DLY +: DLY_W];
        end
      end
      PFD_CLR: begin
        if (st_reg.dcnt <= DLY_W'(1)) begin
          st_next.pst = PFD_IDLE; // RULE13
          st_next.up  = 1'b0;
          st_next.dn  = 1'b0;
        end else begin
          st_next.dcnt = st_reg.dcnt - DLY_W'(1);
        end
      end
      default: st_next.pst = PFD_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg      <= '0;
      st_reg.ctrl <= CTRL_RST;
      st_reg.intv <= INT_RST;
      st_reg.den  <= DEN_RST;
      st_reg.refc <= REF_RST;
      st_reg.pst  <= PFD_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata    = st_reg.prdata;
  assign pready    = st_reg.pready;
  assign pslverr   = st_reg.pslverr;
  assign fb_pulse  = st_reg.fb;
  assign pfd_up    = st_reg.up;
  assign pfd_down  = st_reg.dn;
  assign cal_start = st_reg.cal_start;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  AST_APB_WAIT: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
    else $error("apb answer not one cycle into access");
  AST_CAL_PULSE: assert property (cal_req |=> cal_start) // RULE15
    else $error("calibration not started");
  AST_CAL_CAUSE: assert property (cal_start |-> $past(cal_req)) // RULE15
    else $error("calibration started without write");
  // only while the doubler stays set; clearing it mid-count legally shortens the gap
  AST_BY4_SPACING: assert property (pre_pulse && st_reg.ctrl[C_VDBL] // RULE14
    ##1 st_reg.ctrl[C_VDBL][*2]
    |=> !pre_pulse && !$past(pre_pulse) && !$past(pre_pulse, 2))
    else $error("prescaler not dividing by four");
  AST_FB_ON_WRAP: assert property (fb_pulse |-> $past(div_evt)) // RULE1
    else $error("feedback pulse without counter wrap");
  AST_INT_RELOAD: assert property (div_evt && order == 3'h0 && st_reg.intv != '0 // RULE1
    |=> st_reg.ncnt == (N_W + 1)'($past(st_reg.intv)) - (N_W + 1)'(1))
    else $error("integer mode modulus not integer value");
  AST_PFD_UP: assert property (st_reg.pst == PFD_IDLE && ref_pd && !st_reg.fb // RULE13
    |=> pfd_up && !pfd_down)
    else $error("reference lead gave no up pulse");
  AST_PFD_CLR: assert property (st_reg.pst == PFD_CLR && st_reg.dcnt <= DLY_W'(1) // RULE13
    |=> !pfd_up && !pfd_down)
    else $error("detector outputs not cleared");
  AST_DEN_NONZERO: assert property (st_reg.den != '0) // RULE3
    else $error("denominator zero");
  AST_SEED_PEND: assert property (seed_wr |=> st_reg.seed_pend) // RULE16
    else $error("seed write lost");
endmodule : fractional_n_feedback_divider
`default_nettype wire

// ### osc_ref_source.sv
// Purpose: far-side model: prescaler-side oscillator ticks and reference edges
// Assumes: pulses one cycle wide, launched just after a rising pclk edge
// Notes:   a gap of 1 gives a pulse every cycle; off means the line stays low
`timescale 1ns/1ps
`default_nettype none
module osc_ref_source (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // pacing controls
  input  wire logic       osc_on,
  input  wire logic [7:0] osc_gap,
  input  wire logic       ref_on,
  input  wire logic [7:0] ref_gap,
  // pulses towards the divider
  output logic            osc_tick,
  output logic            ref_edge
);
  logic [7:0] osc_cnt;
  logic [7:0] ref_cnt;

  // free-running pacers, so slow and prompt oscillators share one path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_cnt  <= 8'h00;
      ref_cnt  <= 8'h00;
      osc_tick <= 1'b0;
      ref_edge <= 1'b0;
    end else begin
      osc_cnt  <= (osc_cnt + 8'h01 >= osc_gap) ? 8'h00 : osc_cnt + 8'h01;
      ref_cnt  <= (ref_cnt + 8'h01 >= ref_gap) ? 8'h00 : ref_cnt + 8'h01;
      osc_tick <= osc_on & (osc_cnt == 8'h00);
      ref_edge <= ref_on & (ref_cnt == 8'h00);
    end
  end
endmodule : osc_ref_source
`default_nettype wire

// ### fractional_n_feedback_divider_bench.sv
// Purpose: self-checking bench of the fractional-N feedback divider
// Assumes: apb slave answers with wait states; ticks come every cycle when on
// Notes:   register model and division figures are reckoned here, not read back
`timescale 1ns/1ps
`default_nettype none
module fractional_n_feedback_divider_bench;
  import fnd_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [7:0]  paddr, osc_gap, ref_gap;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, err, osc_tick, ref_edge, osc_on, ref_on;
  logic        fb_pulse, pfd_up, pfd_down, cal_start;
  logic [31:0] model [7];
  int          mismatches, check_count, cal_seen, cyc, nint;
  integer      seed;
  longint      expect_cyc;
  int          f_ord [5] = '{1, 2, 3, 4, 1};
  int          f_int [5] = '{11, 16, 18, 30, 16};
  logic [31:0] f_num [5] = '{32'h1, 32'h1, 32'h3, 32'h1, 32'h8000_0000};
  logic [31:0] f_den [5] = '{32'h4, 32'h4, 32'h4, 32'h4, 32'hffff_ffff};
  int          dly   [5] = '{1, 1, 2, 2, 8};

  fractional_n_feedback_divider #(.ORDERS(4)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc_tick(osc_tick), .ref_edge(ref_edge), .fb_pulse(fb_pulse), .pfd_up(pfd_up),
    .pfd_down(pfd_down), .cal_start(cal_start));

  osc_ref_source partner (
    .pclk(pclk), .presetn(presetn), .osc_on(osc_on), .osc_gap(osc_gap),
    .ref_on(ref_on), .ref_gap(ref_gap), .osc_tick(osc_tick), .ref_edge(ref_edge));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  always @(posedge pclk) if (cal_start === 1'b1) cal_seen++;

  initial begin
    repeat (60000) @(posedge pclk);
    mismatches++;
    test_done();
  end

  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  task test_done;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no limit of its own: the watchdog ends a hung transfer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle cycle keeps psel from being driven twice in one step
    @(posedge pclk);
  endtask : apb

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    check({31'h0, err}, {31'h0, a > A_STAT});
    if (a == A_CTRL) model[0] = d & 32'hffff_fffe;
    else if (a == A_INT) model[1] = {20'h0, d[11:0]};
    else if (a == A_DEN) model[3] = (d == 32'h0) ? 32'h1 : d;
    else if (a < A_STAT) model[a[4:2]] = d;
  endtask : wr

  task rdchk(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
    check(rd, (a > A_STAT) ? 32'h0 : model[a[4:2]]);
    check({31'h0, err}, {31'h0, a > A_STAT});
  endtask : rdchk

  task wait_fb;
    do begin
      @(posedge pclk);
    end while (fb_pulse !== 1'b1);
  endtask : wait_fb

  task span(input int k);
    cyc = 0;
    repeat (k) begin
      do begin
        @(posedge pclk);
        cyc++;
      end while (fb_pulse !== 1'b1);
    end
  endtask : span

  function automatic logic [31:0] cw(input int o, input int p4, input int vd, input int dl);
    return (32'(o) << C_ORD) | (32'(p4) << C_PRE4) | (32'(vd) << C_VDBL) | (32'(dl) << C_DLY);
  endfunction : cw

  initial begin
    seed = 32'hadd2;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {osc_on, ref_on} = 2'b00;
    osc_gap = 8'h01;
    ref_gap = 8'h03;
    model = '{CTRL_RST, {20'h0, INT_RST}, 32'h0, DEN_RST, 32'h0, REF_RST, 32'h0};
    presetn = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int a = 0; a < 6; a++) rdchk(8'(a * 4));
    apb(1'b0, A_STAT, 32'h0);
    check({30'h0, rd[5:4]}, 32'h0);
    $display("done: reset values");
    // two reference edges, one kept by the doubler, with the oscillator still: detector must pull up
    ref_on <= 1'b1;
    repeat (5) @(posedge pclk);
    ref_on <= 1'b0;
    repeat (10) @(posedge pclk);
    check({30'h0, pfd_up, pfd_down}, 32'h2);
    osc_on <= 1'b1;
    wait_fb();
    repeat (12) @(posedge pclk);
    check({30'h0, pfd_up, pfd_down}, 32'h0);
    $display("done: detector");
    wr(A_INT, 32'hffff_fabc);
    rdchk(A_INT);
    wr(A_DEN, 32'h0);
    rdchk(A_DEN);
    wr(A_DEN, 32'hffff_ffff);
    rdchk(A_DEN);
    // seed lands at the first fractional wrap, so it must stay below a denominator of four
    wr(A_SEED, $random(seed) & 32'h3);
    rdchk(A_SEED);
    wr(A_REF, $random(seed) & 32'hffff_fffe);
    rdchk(A_REF);
    wr(A_STAT, 32'hffff_ffff);
    rdchk(A_CTRL);
    wr(8'h1c, 32'h1234_5678);
    rdchk(8'h1c);
    $display("done: register access");
    wr(A_CTRL, cw(0, 0, 0, 1) | 32'h1);
    repeat (3) @(posedge pclk);
    check(32'(cal_seen), 32'h1);
    rdchk(A_CTRL);
    wr(A_CTRL, cw(0, 0, 0, 1));
    repeat (3) @(posedge pclk);
    check(32'(cal_seen), 32'h1);
    $display("done: calibration");
    wr(A_REF, REF_RST);
    for (int m = 0; m < 3; m++) begin
      nint = 9 + ($random(seed) & 63);
      wr(A_INT, 32'(nint));
      wr(A_CTRL, cw(0, m == 1, m == 2, 1));
      wait_fb();
      wait_fb();
      span(1);
      check(32'(cyc), 32'((m == 0 ? 2 : 4) * nint));
      apb(1'b0, A_STAT, 32'h0);
      check({31'h0, rd[3]}, {31'h0, m != 0});
    end
    $display("done: integer division");
    for (int i = 0; i < 5; i++) begin
      wr(A_INT, 32'(f_int[i]));
      wr(A_DEN, f_den[i]);
      wr(A_NUM, f_num[i]);
      wr(A_CTRL, cw(f_ord[i], 0, 0, dly[f_ord[i]]));
      repeat (3) wait_fb();
      span(64);
      expect_cyc = 2 * (64 * longint'(f_int[i]) + (64 * longint'(f_num[i])) / f_den[i]);
      // shaping leaves a few cycles of edge error at the window ends
      check({31'h0, (cyc - expect_cyc <= 16) && (expect_cyc - cyc <= 16)}, 32'h1);
    end
    $display("done: fractional division");
    wr(A_NUM, 32'h0);
    wr(A_CTRL, cw(0, 1, 0, 1) | (32'h3 << C_LOW));
    apb(1'b0, A_STAT, 32'h0);
    check({30'h0, rd[5:4]}, 32'h1);
    wr(A_CTRL, cw(0, 0, 0, 1) | (32'h3 << C_HIGH) | (32'h3 << C_LOOP));
    apb(1'b0, A_STAT, 32'h0);
    check({30'h0, rd[5:4]}, 32'h2);
    wr(A_CTRL, CTRL_RST);
    apb(1'b0, A_STAT, 32'h0);
    check({30'h0, rd[5:4]}, 32'h0);
    $display("done: detector modes");
    test_done();
  end
endmodule : fractional_n_feedback_divider_bench
`default_nettype wire
